// ==== hw/crcu_pkg.sv ====
// Constants for the clock and reset configuration unit.
// Assumes a 32-bit APB slave port with byte strobes, one clock.
package crcu_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CRCU_OFF_RSTSRC = 8'h24;
    localparam logic [7:0] CRCU_OFF_AHBRST = 8'h28;
    localparam logic [7:0] CRCU_OFF_CFG = 8'h2C;
    localparam logic [7:0] CRCU_OFF_DSV = 8'h34;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CRCU_FLAG_LSB = 26;
    localparam int CRCU_FLAG_N = 6;
    localparam int CRCU_RESET_FLAG_CLEAR_BIT = 24;
    localparam int CRCU_LSI_STB_BIT = 1;
    localparam int CRCU_LSI_EN_BIT = 0;
    localparam int CRCU_USB_RST_BIT = 12;
    localparam int CRCU_I2SB_BIT = 18;
    localparam int CRCU_I2SA_BIT = 17;
    localparam int CRCU_PDA_SRC_BIT = 16;
    localparam int CRCU_PLLC_LSB = 12;
    localparam int CRCU_PLLB_LSB = 8;
    localparam int CRCU_PDB_LSB = 4;
    localparam int CRCU_PDA_LSB = 0;
    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [5:0] CRCU_FLAG_RST = 6'h03;
    localparam logic [31:0] CRCU_RSTSRC_RST = 32'h0C000000;
    localparam logic [31:0] CRCU_AHBRST_RST = 32'h00000000;
    localparam logic [31:0] CRCU_CFG_RST = 32'h00000000;
    localparam logic [31:0] CRCU_DSV_RST = 32'h00000000;
    localparam logic [31:0] CRCU_AHBRST_WMASK = 32'h00001000;
    localparam logic [31:0] CRCU_CFG_WMASK = 32'h0007FFFF;
    localparam logic [31:0] CRCU_DSV_WMASK = 32'h00000003;
    // Multiplier decode: lowest legal code, top code and its factor
    localparam logic [3:0] CRCU_MF_MIN = 4'h6;
    localparam logic [3:0] CRCU_MF_TOP = 4'hF;
    localparam logic [4:0] CRCU_MF_OFS = 5'h02;
    localparam logic [4:0] CRCU_MF_TOP_FAC = 5'h14;
endpackage

// ==== hw/crcu_top.sv ====
// Clock and reset configuration unit: register file and control outputs.
// Assumes an APB4 master on pclk; reset sources and oscillator ready are
// asynchronous and are synchronised here.
// Operation
// - Writing one to reset_flag_clear clears all reset-cause flags; zero leaves them.
// - lsirc_stable_flag is set by hardware when the slow oscillator is stable.
// - lsirc_enable is software read/write and switches the slow oscillator.
// - usb_fs_reset high holds the USB full-speed controller in reset.
// - i2s_b_clk_select picks system clock or twice pll_c_clock.
// - i2s_a_clk_select picks system clock or twice pll_c_clock.
// - prediv_a_src_select picks high_speed_crystal or pll_b_clock.
// - pll_c_mult codes 6..14 give 8..16, code 15 gives 20, rest reserved.
// - pll_b_mult uses the same multiplier coding.
// - prediv_b_factor divides its input by field plus one.
// - prediv_a_factor divides its selected input by field plus one.
// - prediv_a_factor bit 0 is shared storage with clock_config_reg0 bit 17.
// - deep_sleep_core_volt selects 1.2V, 1.1V, 1.0V or 0.9V.
// - All registers accept byte, half-word and word accesses.
// - USB reset, PLL config and voltage registers reset to zero.
// - Cause flags 31..26 set by their reset source, cleared only by reset_flag_clear.
// - Cause register resets to 0x0C000000; flags only on power reset.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module crcu_top #(
    parameter int FLAG_N = crcu_pkg::CRCU_FLAG_N
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic power_resetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [FLAG_N-1:0] reset_event,
    input wire logic lsirc_ready,
    input wire logic cfg0_bit17_we,
    input wire logic cfg0_bit17_wdata,
    output logic lsirc_enable,
    output logic usb_fs_reset,
    output logic i2s_b_clk_select,
    output logic i2s_a_clk_select,
    output logic prediv_a_src_select,
    output logic [3:0] prediv_a_factor,
    output logic [4:0] prediv_a_divisor,
    output logic [4:0] prediv_b_divisor,
    output logic [4:0] pll_b_factor,
    output logic [4:0] pll_c_factor,
    output logic [1:0] deep_sleep_core_volt
);
    // ------------------------------------------------------------
    // Multiplier decode, used for both PLLs; zero marks reserved
    // ------------------------------------------------------------
    function automatic logic [4:0] crcu_mf_decode(input logic [3:0] code);
        logic [4:0] f;
        f = 5'h00;
        if (code == crcu_pkg::CRCU_MF_TOP)
            f = crcu_pkg::CRCU_MF_TOP_FAC;
        else if (code >= crcu_pkg::CRCU_MF_MIN)
            f = {1'b0, code} + crcu_pkg::CRCU_MF_OFS;
        return f;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [FLAG_N-1:0] flags_r;
    logic [FLAG_N-1:0] evt_s1_r;
    logic [FLAG_N-1:0] evt_s2_r;
    logic lsi_s1_r;
    logic lsi_s2_r;
    logic reset_flag_clear_r;
    logic lsi_en_r;
    logic lsi_stb_r;
    logic [31:0] ahbrst_r;
    logic [31:0] cfg_r;
    logic [31:0] dsv_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [4:0] pda_div_r;
    logic [4:0] pdb_div_r;
    logic [4:0] pllb_fac_r;
    logic [4:0] pllc_fac_r;

    // ------------------------------------------------------------
    // Address decode and byte-lane write mask
    // ------------------------------------------------------------
    wire logic sel_rst = (paddr == crcu_pkg::CRCU_OFF_RSTSRC);
    wire logic sel_ahb = (paddr == crcu_pkg::CRCU_OFF_AHBRST);
    wire logic sel_cfg = (paddr == crcu_pkg::CRCU_OFF_CFG);
    wire logic sel_dsv = (paddr == crcu_pkg::CRCU_OFF_DSV);
    wire logic mapped = sel_rst | sel_ahb | sel_cfg | sel_dsv;
    // Write commits only at the edge where pready is seen high
    wire logic commit = ce & psel & penable & pready_r;
    wire logic wr_ok = commit & pwrite & mapped;
    wire logic [31:0] lane_m = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Merged write values; reserved bits masked off
    // reserved bits
    wire logic [31:0] ahb_m = lane_m & crcu_pkg::CRCU_AHBRST_WMASK;
    wire logic [31:0] cfg_m = lane_m & crcu_pkg::CRCU_CFG_WMASK;
    wire logic [31:0] dsv_m = lane_m & crcu_pkg::CRCU_DSV_WMASK;
    wire logic [31:0] ahb_nxt = (ahbrst_r & ~ahb_m) | (pwdata & ahb_m);
    wire logic [31:0] dsv_nxt = (dsv_r & ~dsv_m) | (pwdata & dsv_m);
    wire logic [31:0] cfg_bus = (cfg_r & ~cfg_m) | (pwdata & cfg_m);
    wire logic cfg_bus_we = wr_ok & sel_cfg;
    // shared divider bit: bus write wins over the other register
    wire logic pda0_nxt = cfg_bus_we & pstrb[0] ? pwdata[crcu_pkg::CRCU_PDA_LSB]
                        : cfg0_bit17_we ? cfg0_bit17_wdata : cfg_r[crcu_pkg::CRCU_PDA_LSB];
    wire logic [31:0] cfg_nxt = {(cfg_bus_we ? cfg_bus[31:1] : cfg_r[31:1]), pda0_nxt};
    wire logic rst_we0 = wr_ok & sel_rst & pstrb[0];
    wire logic rst_we3 = wr_ok & sel_rst & pstrb[3];

    // clear request; hardware set wins over the clear
    wire logic [FLAG_N-1:0] flags_nxt = (reset_flag_clear_r ? '0 : flags_r) | evt_s2_r;

    // Read mux; unmapped reads as zero with an error
    wire logic [31:0] rst_rd = {flags_r, 1'b0, reset_flag_clear_r, 22'h000000, lsi_stb_r, lsi_en_r};
    wire logic [31:0] rd_mux = sel_rst ? rst_rd
                             : sel_ahb ? ahbrst_r
                             : sel_cfg ? cfg_r
                             : sel_dsv ? dsv_r : 32'h00000000;

    // ------------------------------------------------------------
    // Power-domain part: cause flags and their synchronisers
    // ------------------------------------------------------------
    // flags survive system reset; power reset loads CRCU_FLAG_RST, reset_flag_clear clears them
    always_ff @(posedge pclk or negedge power_resetn)
    begin
        if (!power_resetn)
        begin
            evt_s1_r <= '0;
            evt_s2_r <= '0;
            flags_r <= crcu_pkg::CRCU_FLAG_RST;
        end
        else if (ce)
        begin
            evt_s1_r <= reset_event;
            evt_s2_r <= evt_s1_r;
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------
    // System-reset registers
    // ------------------------------------------------------------
    // zero reset values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ahbrst_r <= crcu_pkg::CRCU_AHBRST_RST;
            cfg_r <= crcu_pkg::CRCU_CFG_RST;
            dsv_r <= crcu_pkg::CRCU_DSV_RST;
            reset_flag_clear_r <= 1'b0;
            lsi_en_r <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ok & sel_ahb)
                ahbrst_r <= ahb_nxt;
            cfg_r <= cfg_nxt;
            if (wr_ok & sel_dsv)
                dsv_r <= dsv_nxt;
            if (rst_we0)
                lsi_en_r <= pwdata[crcu_pkg::CRCU_LSI_EN_BIT];
            if (rst_we3)
                reset_flag_clear_r <= pwdata[crcu_pkg::CRCU_RESET_FLAG_CLEAR_BIT];
        end
    end

    // Oscillator ready sync; a disabled oscillator never reads stable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lsi_s1_r <= 1'b0;
            lsi_s2_r <= 1'b0;
            lsi_stb_r <= 1'b0;
        end
        else if (ce)
        begin
            lsi_s1_r <= lsirc_ready;
            lsi_s2_r <= lsi_s1_r;
            lsi_stb_r <= lsi_s2_r & lsi_en_r;
        end
    end

    // Decoded factors, registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pda_div_r <= 5'h01;
            pdb_div_r <= 5'h01;
            pllb_fac_r <= 5'h00;
            pllc_fac_r <= 5'h00;
        end
        else if (ce)
        begin
            pda_div_r <= {1'b0, cfg_r[crcu_pkg::CRCU_PDA_LSB +: 4]} + 5'h01;
            pdb_div_r <= {1'b0, cfg_r[crcu_pkg::CRCU_PDB_LSB +: 4]} + 5'h01;
            pllb_fac_r <= crcu_mf_decode(cfg_r[crcu_pkg::CRCU_PLLB_LSB +: 4]);
            pllc_fac_r <= crcu_mf_decode(cfg_r[crcu_pkg::CRCU_PLLC_LSB +: 4]);
        end
    end

    // APB answer: one wait state, data captured in the wait cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (ce)
        begin
            pready_r <= psel & penable & ~pready_r;
            prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rd_mux : 32'h00000000;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign lsirc_enable = lsi_en_r;
    // reset held while bit is one
    assign usb_fs_reset = ahbrst_r[crcu_pkg::CRCU_USB_RST_BIT];
    assign i2s_b_clk_select = cfg_r[crcu_pkg::CRCU_I2SB_BIT];
    assign i2s_a_clk_select = cfg_r[crcu_pkg::CRCU_I2SA_BIT];
    assign prediv_a_src_select = cfg_r[crcu_pkg::CRCU_PDA_SRC_BIT];
    assign prediv_a_factor = cfg_r[crcu_pkg::CRCU_PDA_LSB +: 4];
    assign prediv_a_divisor = pda_div_r;
    assign prediv_b_divisor = pdb_div_r;
    assign pll_b_factor = pllb_fac_r;
    assign pll_c_factor = pllc_fac_r;
    assign deep_sleep_core_volt = dsv_r[1:0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    flag_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn || !power_resetn)
        (ce && reset_flag_clear_r && evt_s2_r == '0) |=> flags_r == '0)
        else $error("cause flags not cleared");
    flag_set_a: assert property (
        @(posedge pclk) disable iff (!power_resetn)
        (ce && evt_s2_r[0]) |=> flags_r[0])
        else $error("cause flag set lost");
    flag_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn || !power_resetn)
        (ce && !reset_flag_clear_r && flags_r[1]) |=> flags_r[1])
        else $error("cause flag dropped without clear");
    lsi_stable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && !lsi_en_r) |=> !lsi_stb_r)
        else $error("stable flag set while oscillator off");
    usb_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && sel_ahb && pstrb[1] && pwdata[12]) |=> usb_fs_reset)
        else $error("usb reset not applied");
    apb_answer_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pready_r) |=> pready_r ##1 (!pready_r || !ce))
        else $error("apb answer timing wrong");
    mult_top_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && cfg_r[15:12] == 4'hF) |=> pll_c_factor == 5'h14)
        else $error("top multiplier code not twenty");
    mult_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && cfg_r[11:8] == 4'h6) |=> pll_b_factor == 5'h08)
        else $error("lowest multiplier code not eight");
    div_b_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && cfg_r[7:4] == 4'hF) |=> prediv_b_divisor == 5'h10)
        else $error("divider code fifteen not sixteen");
    shared_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && cfg0_bit17_we && !(cfg_bus_we && pstrb[0]))
        |=> prediv_a_factor[0] == $past(cfg0_bit17_wdata))
        else $error("shared divider bit not written");
    reserved_rd_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pready_r && sel_dsv) |-> prdata_r[31:2] == 30'h00000000)
        else $error("reserved bits read nonzero");
endmodule

// ==== dv/test_clock_reset_config_unit.sv ====
// Self-checking bench for the clock and reset configuration unit.
// Assumes crcu_pkg is compiled first; the bench is the only APB master.
`timescale 1ns/1ps
module test_clock_reset_config_unit;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic power_resetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [5:0] reset_event = 6'h00;
    logic lsirc_ready = 1'b0;
    logic cfg0_bit17_we = 1'b0;
    logic cfg0_bit17_wdata = 1'b0;
    logic pready, pslverr, lsirc_enable, usb_fs_reset;
    logic i2s_b_clk_select, i2s_a_clk_select, prediv_a_src_select;
    logic [31:0] prdata;
    logic [3:0] prediv_a_factor;
    logic [4:0] prediv_a_divisor, prediv_b_divisor, pll_b_factor, pll_c_factor;
    logic [1:0] deep_sleep_core_volt;
    int err_count = 0;
    int samples_checked = 0;

    // ----------------------------------------
    // Clock, device and shared helpers
    // ----------------------------------------
    // 40 ns period
    always #20 pclk = ~pclk;

    crcu_top dut (.pclk(pclk), .presetn(presetn), .power_resetn(power_resetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .reset_event(reset_event), .lsirc_ready(lsirc_ready), .cfg0_bit17_we(cfg0_bit17_we),
        .cfg0_bit17_wdata(cfg0_bit17_wdata), .lsirc_enable(lsirc_enable),
        .usb_fs_reset(usb_fs_reset), .i2s_b_clk_select(i2s_b_clk_select),
        .i2s_a_clk_select(i2s_a_clk_select), .prediv_a_src_select(prediv_a_src_select),
        .prediv_a_factor(prediv_a_factor), .prediv_a_divisor(prediv_a_divisor),
        .prediv_b_divisor(prediv_b_divisor), .pll_b_factor(pll_b_factor),
        .pll_c_factor(pll_c_factor), .deep_sleep_core_volt(deep_sleep_core_volt));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; pready, prdata and pslverr are taken at the rising edge
    // where pready is sampled high, and the request is held until that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? s : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, then wait past the commit edge so register outputs have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, s, rd, er);
        @(negedge pclk);
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, 4'h0, rd, er);
        chk(name, exp, rd);
        chk({name, " err"}, {31'h0, a == 8'h30}, {31'h0, er});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        rdchk("cause", 8'h24, 32'h0C000000);
        rdchk("usb", 8'h28, 32'h0);
        rdchk("cfg", 8'h2C, 32'h0);
        rdchk("dsv", 8'h34, 32'h0);
        chk("div a", 32'h1, {27'h0, prediv_a_divisor});
        $display("test reset values done");
    endtask

    // Reserved bits and an unmapped place
    task automatic t_masks();
        wr(8'h28, 32'hFFFFFFFF, 4'hF);
        rdchk("usb", 8'h28, 32'h00001000);
        chk("usb out", 32'h1, {31'h0, usb_fs_reset});
        wr(8'h28, 32'h0, 4'hF);
        chk("usb out", 32'h0, {31'h0, usb_fs_reset});
        wr(8'h30, 32'hFFFFFFFF, 4'hF);
        rdchk("unmapped", 8'h30, 32'h0);
        wr(8'h2C, 32'hFFFFFFFF, 4'hF);
        rdchk("cfg", 8'h2C, 32'h0007FFFF);
        wr(8'h2C, 32'h0, 4'hF);
        $display("test masks done");
    endtask

    // Byte lane writes touch only their own lane
    task automatic t_lanes();
        wr(8'h2C, 32'hFFFA0000, 4'h4);
        rdchk("cfg lane", 8'h2C, 32'h00020000);
        wr(8'h2C, 32'h00050000, 4'h4);
        rdchk("cfg lane", 8'h2C, 32'h00050000);
        chk("i2s b", 32'h1, {31'h0, i2s_b_clk_select});
        chk("i2s a", 32'h0, {31'h0, i2s_a_clk_select});
        chk("src a", 32'h1, {31'h0, prediv_a_src_select});
        wr(8'h2C, 32'h0000ABCD, 4'h3);
        rdchk("cfg half", 8'h2C, 32'h0005ABCD);
        $display("test lanes done");
    endtask

    // Every multiplier and divider code, then every voltage code
    task automatic t_codes();
        logic [4:0] m;
        for (int k = 0; k < 16; k++)
        begin
            m = (k < 6) ? 5'h00 : (k == 15) ? 5'h14 : 5'(k + 2);
            wr(8'h2C, {16'h0, 4'(k), 4'(15 - k), 4'(k), 4'(15 - k)}, 4'h3);
            // Decoded outputs follow the field one edge later
            @(negedge pclk);
            chk("pll c", {27'h0, m}, {27'h0, pll_c_factor});
            chk("div a", 32'(16 - k), {27'h0, prediv_a_divisor});
            chk("div b", 32'(k + 1), {27'h0, prediv_b_divisor});
            chk("fac a", 32'(15 - k), {28'h0, prediv_a_factor});
            wr(8'h2C, {20'h0, 4'(k), 8'h00}, 4'h2);
            @(negedge pclk);
            chk("pll b", {27'h0, m}, {27'h0, pll_b_factor});
        end
        for (int v = 0; v < 4; v++)
        begin
            wr(8'h34, {30'h0, 2'(v)}, 4'h1);
            chk("volt", 32'(v), {30'h0, deep_sleep_core_volt});
        end
        $display("test codes done");
    endtask

    // Shared divider bit written from the other register
    task automatic t_shared();
        wr(8'h2C, 32'h0, 4'h1);
        @(posedge pclk);
        cfg0_bit17_we <= 1'b1;
        cfg0_bit17_wdata <= 1'b1;
        @(posedge pclk);
        cfg0_bit17_we <= 1'b0;
        rdchk("shared", 8'h2C, 32'h00050F01);
        chk("shared out", 32'h1, {31'h0, prediv_a_factor[0]});
        $display("test shared bit done");
    endtask

    // Cause flags, clear bit and slow oscillator
    task automatic t_flags();
        wr(8'h24, 32'h01000001, 4'hF);
        rdchk("clear", 8'h24, 32'h01000001);
        wr(8'h24, 32'h00000001, 4'hF);
        chk("lsi en", 32'h1, {31'h0, lsirc_enable});
        for (int k = 0; k < 6; k++)
        begin
            @(posedge pclk);
            reset_event <= 6'(1 << k);
            repeat (5) @(posedge pclk);
            reset_event <= 6'h00;
            repeat (4) @(posedge pclk);
            rdchk("flag", 8'h24, (32'h1 << (26 + k)) | 32'h1);
            wr(8'h24, 32'h00000001, 4'hF);
            rdchk("flag kept", 8'h24, (32'h1 << (26 + k)) | 32'h1);
            wr(8'h24, 32'h01000001, 4'hF);
            wr(8'h24, 32'h00000001, 4'hF);
        end
        // Clock enable low: a cause event must not be captured
        @(posedge pclk);
        ce <= 1'b0;
        reset_event <= 6'h01;
        repeat (5) @(posedge pclk);
        reset_event <= 6'h00;
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk("frozen", 8'h24, 32'h00000001);
        lsirc_ready <= 1'b1;
        repeat (5) @(posedge pclk);
        rdchk("stable", 8'h24, 32'h00000003);
        lsirc_ready <= 1'b0;
        repeat (5) @(posedge pclk);
        rdchk("unstable", 8'h24, 32'h00000001);
        reset_event <= 6'h20;
        repeat (5) @(posedge pclk);
        reset_event <= 6'h00;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("sys reset", 8'h24, 32'h80000000);
        $display("test flags done");
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog at 20000 cycles, well beyond the roughly 510 cycles the tests need
    initial
    begin
        #(40 * 20000);
        err_count++;
        test_done();
    end

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        power_resetn <= 1'b1;
        t_reset_values();
        t_masks();
        t_lanes();
        t_codes();
        t_shared();
        t_flags();
        test_done();
    end
endmodule
